// *** shared/t0_pkg.sv ***
// constants and types shared by both ends of the t0 apdu transport link
package t0_pkg;
    // ------------------------------------------------------------
    // procedure and status bytes
    // ------------------------------------------------------------
    localparam logic [7:0] sw1_more = 8'h61;
    localparam logic [7:0] sw1_relen = 8'h6c;
    localparam logic [7:0] sw1_warn_a = 8'h62;
    localparam logic [7:0] sw1_warn_b = 8'h63;
    localparam logic [7:0] sw1_ok = 8'h90;
    localparam logic [7:0] sw2_ok = 8'h00;
    localparam logic [7:0] sw1_err = 8'h6f;
    localparam logic [7:0] sw2_err = 8'h00;
    localparam logic [7:0] sw1_abort = 8'h64;
    localparam logic [7:0] sw2_abort = 8'h00;
    localparam logic [7:0] ins_get_response = 8'hc0;
    localparam logic [7:0] ins_get_data = 8'hca;
    localparam logic [7:0] p3_zero = 8'h00;
    localparam logic [7:0] p3_min_case3 = 8'h01;
    // ------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------
    localparam int hdr_len = 5;
    localparam int buf_depth = 2;
    localparam logic [8:0] avail_reset = 9'h020;
    localparam logic [7:0] chunk_reset = 8'hff;
    localparam logic [8:0] full_256 = 9'h100;
    localparam logic [2:0] idx_reset = 3'h0;
    localparam logic [8:0] cnt_reset = 9'h000;

    typedef enum logic [1:0] {
        case1 = 2'b00,
        case2 = 2'b01,
        case3 = 2'b10,
        case4 = 2'b11
    } apdu_case_t;

    // warning or application status that lets case 4 continue
    function automatic logic is_continue_status(input logic [7:0] sw1,
                                                input logic [7:0] sw2);
        is_continue_status = (sw1 == sw1_warn_a) || (sw1 == sw1_warn_b) ||
            ((sw1[7:4] == 4'h9) && !((sw1 == sw1_ok) && (sw2 == sw2_ok)));
    endfunction : is_continue_status
endpackage : t0_pkg

// *** shared/t0_link_if.sv ***
// byte stream link between terminal transport layer and card
`timescale 1ns/1ns
`default_nettype none
interface t0_link_if (
    input wire logic clk,
    input wire logic nrst
);
    // terminal to card bytes
    logic [7:0] cmd_data;
    logic cmd_valid;
    logic cmd_ready;
    // card to terminal bytes
    logic [7:0] rsp_data;
    logic rsp_valid;
    logic rsp_ready;

    modport terminal (
        input clk, nrst,
        output cmd_data, cmd_valid,
        input cmd_ready,
        input rsp_data, rsp_valid,
        output rsp_ready
    );
    modport card (
        input clk, nrst,
        input cmd_data, cmd_valid,
        output cmd_ready,
        output rsp_data, rsp_valid,
        input rsp_ready
    );
endinterface : t0_link_if
`default_nettype wire

// *** hdl/byte_skid.sv ***
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module byte_skid (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [7:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    typedef struct packed {
        logic [1:0][7:0] mem;
        logic rd;
        logic wr;
        logic [1:0] cnt;
    } skid_t;

    skid_t r;
    skid_t next_r;

    assign in_ready = (r.cnt != 2'h2);
    assign out_valid = (r.cnt != 2'h0);
    assign out_data = r.mem[r.rd];

    always_comb begin
        next_r = r;
        if (in_valid && in_ready) begin
            next_r.mem[r.wr] = in_data;
            next_r.wr = ~r.wr;
        end
        if (out_valid && out_ready) begin
            next_r.rd = ~r.rd;
        end
        next_r.cnt = r.cnt + {1'b0, in_valid && in_ready}
            - {1'b0, out_valid && out_ready};
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule : byte_skid
`default_nettype wire

// *** hdl/t0_card.sv ***
// card end: interprets t0 headers and paces data with procedure bytes
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - terminal swallows 61/6c pairs as unfinished
// - terminal ends command on any other status
// - status always refers to latest command
// - case 1 header p3 zero, status only
// - card tells case 1 from case 2
// - case 2 returns data then status
// - case 3 length between 1 and 255
// - terminal sends data or stops on status
// - case 3 status after all data
// - terminal drops le for case 4
// - case 4 answers 61xx after data
// - get response p3 at most xx
// - warning status continues with get response
// - other status ends; get response as case 2
// - 6cxx resends header with new p3
// - 61/6c only for case 2 and 4; card also sends 61 after case 3 data when avail_len is nonzero
// - le too big or zero short: 6c
// - le equal available: data, 61, error; card sends data then 9000, or 61 chunk_max first if le exceeds chunk_max
// - le short: data then 61 remaining
// - errors may replace procedure bytes
module t0_card (
    t0_link_if.card link,
    input wire logic [8:0] avail_len,
    input wire logic [7:0] chunk_max,
    input wire logic force_error,
    output logic [7:0] last_ins,
    output logic cmd_done
);
    typedef enum logic [2:0] {
        st_hdr = 3'b000,
        st_decide = 3'b001,
        st_rx_data = 3'b010,
        st_tx_ack = 3'b011,
        st_tx_data = 3'b100,
        st_tx_sw1 = 3'b101,
        st_tx_sw2 = 3'b110
    } card_st_t;

    typedef struct packed {
        card_st_t st;
        logic [4:0][7:0] hdr;
        logic [2:0] idx;
        logic [8:0] cnt;
        logic [8:0] pend;
        logic pend_valid;
        logic [7:0] sw1;
        logic [7:0] sw2;
        logic [7:0] tx;
        logic tx_valid;
        logic [7:0] last_ins;
        logic done;
    } card_t;

    card_t r;
    card_t next_r;
    logic [7:0] out_data;
    logic out_valid;
    logic out_ready;

    // response bytes pass a two-entry buffer so a stall loses nothing
    byte_skid i_byte_skid (
        .clk(link.clk),
        .nrst(link.nrst),
        .in_data(r.tx),
        .in_valid(r.tx_valid),
        .in_ready(out_ready),
        .out_data(out_data),
        .out_valid(out_valid),
        .out_ready(link.rsp_ready)
    );
    assign link.rsp_data = out_data;
    assign link.rsp_valid = out_valid;
    assign link.cmd_ready = (r.st == st_hdr) || (r.st == st_rx_data);
    assign last_ins = r.last_ins;
    assign cmd_done = r.done;

    function automatic logic [8:0] le_of(input logic [7:0] p3);
        le_of = (p3 == t0_pkg::p3_zero) ? t0_pkg::full_256 : {1'b0, p3};
    endfunction : le_of

    logic [8:0] total;
    logic [8:0] le;
    logic [7:0] ins;
    logic [7:0] p3;
    logic is_get;
    logic is_case2;
    logic [7:0] chunk;
    always_comb begin
        ins = r.hdr[1];
        p3 = r.hdr[4];
        is_get = (ins == t0_pkg::ins_get_response);
        // a zero-length header is case 2 only for data-returning ins
        is_case2 = is_get || (ins == t0_pkg::ins_get_data);
        total = (is_get && r.pend_valid) ? r.pend : avail_len;
        le = le_of(p3);
        chunk = (total[7:0] < chunk_max && !total[8]) ? total[7:0]
            : chunk_max;
    end

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        if (r.tx_valid && out_ready) begin
            next_r.tx_valid = 1'b0;
        end
        case (r.st)
            st_hdr: begin
                if (link.cmd_valid) begin
                    next_r.hdr[r.idx] = link.cmd_data;
                    next_r.idx = r.idx + 3'h1;
                    if (r.idx == 3'(t0_pkg::hdr_len - 1)) begin
                        next_r.idx = t0_pkg::idx_reset;
                        next_r.st = st_decide;
                    end
                end
            end
            st_decide: begin
                next_r.last_ins = ins;
                next_r.st = st_tx_sw1;
                next_r.sw1 = t0_pkg::sw1_ok;
                next_r.sw2 = t0_pkg::sw2_ok;
                next_r.cnt = t0_pkg::cnt_reset;
                if (force_error) begin
                    // error status stands in for any procedure byte
                    next_r.sw1 = t0_pkg::sw1_err;
                    next_r.sw2 = t0_pkg::sw2_err;
                    next_r.pend_valid = 1'b0;
                end else if (is_case2) begin
                    if (le > total || (p3 == t0_pkg::p3_zero &&
                                       total != t0_pkg::full_256)) begin
                        next_r.sw1 = t0_pkg::sw1_relen;
                        next_r.sw2 = total[7:0];
                    end else if (le == total && le > {1'b0, chunk_max}) begin
                        next_r.sw1 = t0_pkg::sw1_more;
                        next_r.sw2 = chunk_max;
                        next_r.pend = total;
                        next_r.pend_valid = 1'b1;
                    end else begin
                        // data first, then 61 for the rest or ok
                        next_r.cnt = le;
                        next_r.pend = total - le;
                        next_r.pend_valid = (total != le);
                        next_r.tx = ins;
                        next_r.tx_valid = 1'b1;
                        next_r.st = st_tx_ack;
                    end
                end else if (p3 == t0_pkg::p3_zero) begin
                    next_r.pend_valid = 1'b0; // case 1 status only
                end else begin
                    // ack with ins, then accept p3 data bytes
                    next_r.cnt = {1'b0, p3};
                    next_r.tx = ins;
                    next_r.tx_valid = 1'b1;
                    next_r.st = st_tx_ack;
                end
            end
            st_tx_ack: begin
                if (!r.tx_valid || out_ready) begin
                    next_r.st = is_case2 ? st_tx_data : st_rx_data;
                end
            end
            st_rx_data: begin
                if (link.cmd_valid) begin
                    next_r.cnt = r.cnt - 9'h001;
                    if (r.cnt == 9'h001) begin
                        // status only once all data is
                        next_r.st = st_tx_sw1;
                        if (avail_len != t0_pkg::cnt_reset) begin
                            next_r.sw1 = t0_pkg::sw1_more;
                            next_r.sw2 = chunk;
                            next_r.pend = avail_len;
                            next_r.pend_valid = 1'b1;
                        end
                    end
                end
            end
            st_tx_data: begin
                if (!r.tx_valid || out_ready) begin
                    if (r.cnt == t0_pkg::cnt_reset) begin
                        next_r.st = st_tx_sw1;
                        if (r.pend_valid) begin
                            next_r.sw1 = t0_pkg::sw1_more;
                            next_r.sw2 = (r.pend[8] ||
                                r.pend[7:0] > chunk_max) ? chunk_max
                                : r.pend[7:0];
                        end
                    end else begin
                        next_r.tx = r.cnt[7:0] ^ r.hdr[2];
                        next_r.tx_valid = 1'b1;
                        next_r.cnt = r.cnt - 9'h001;
                    end
                end
            end
            st_tx_sw1: begin
                if (!r.tx_valid || out_ready) begin
                    next_r.tx = r.sw1;
                    next_r.tx_valid = 1'b1;
                    next_r.st = st_tx_sw2;
                end
            end
            st_tx_sw2: begin
                if (!r.tx_valid || out_ready) begin
                    // status belongs to the header just decided
                    next_r.tx = r.sw2;
                    next_r.tx_valid = 1'b1;
                    next_r.done = 1'b1;
                    next_r.st = st_hdr;
                end
            end
            default: begin
                next_r.st = st_hdr;
            end
        endcase
    end

    always_ff @(posedge link.clk) begin
        if (!link.nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule : t0_card
`default_nettype wire

// *** hdl/t0_terminal.sv ***
// terminal transport end: maps apdus onto t0 headers and follows the card
`timescale 1ns/1ns
`default_nettype none
module t0_terminal (
    t0_link_if.terminal link,
    input wire logic [4:0][7:0] req_hdr,
    input wire t0_pkg::apdu_case_t req_case,
    input wire logic [7:0] req_le,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_data,
    input wire logic req_data_valid,
    output logic req_data_ready,
    output logic [7:0] resp_data,
    output logic resp_data_valid,
    output logic [7:0] resp_sw1,
    output logic [7:0] resp_sw2,
    output logic resp_done
);
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_hdr = 3'b001,
        st_proc = 3'b010,
        st_data = 3'b011,
        st_sw2 = 3'b100,
        st_rdata = 3'b101
    } term_st_t;

    typedef struct packed {
        term_st_t st;
        logic [4:0][7:0] hdr;
        t0_pkg::apdu_case_t cs;
        logic [2:0] idx;
        logic [8:0] cnt;
        logic after_data;
        logic [7:0] sw1;
        logic [7:0] rd;
        logic rd_valid;
        logic [7:0] out_sw1;
        logic [7:0] out_sw2;
        logic done;
    } term_t;

    term_t r;
    term_t next_r;
    logic [7:0] b;
    logic rx;

    assign b = link.rsp_data;
    assign rx = link.rsp_valid;
    assign req_ready = (r.st == st_idle);
    assign req_data_ready = (r.st == st_data) && link.cmd_ready;
    assign link.rsp_ready = (r.st == st_proc) || (r.st == st_sw2) ||
        (r.st == st_rdata);
    assign link.cmd_valid = (r.st == st_hdr) ||
        ((r.st == st_data) && req_data_valid);
    assign link.cmd_data = (r.st == st_hdr) ? r.hdr[r.idx] : req_data;
    assign resp_data = r.rd;
    assign resp_data_valid = r.rd_valid;
    assign resp_sw1 = r.out_sw1;
    assign resp_sw2 = r.out_sw2;
    assign resp_done = r.done;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.rd_valid = 1'b0;
        case (r.st)
            st_idle: begin
                if (req_valid) begin
                    // keep header for later resends
                    next_r.hdr = req_hdr;
                    next_r.cs = req_case;
                    next_r.after_data = 1'b0;
                    next_r.idx = t0_pkg::idx_reset;
                    // p3 is lc for 3 and 4, le dropped
                    if (req_case == t0_pkg::case1) begin
                        next_r.hdr[4] = t0_pkg::p3_zero;
                    end else if (req_case == t0_pkg::case2) begin
                        next_r.hdr[4] = req_le;
                    end
                    next_r.st = st_hdr;
                end
            end
            st_hdr: begin
                if (link.cmd_ready) begin
                    next_r.idx = r.idx + 3'h1;
                    if (r.idx == 3'(t0_pkg::hdr_len - 1)) begin
                        next_r.st = st_proc;
                        next_r.cnt = {1'b0, r.hdr[4]};
                    end
                end
            end
            st_proc: begin
                if (rx) begin
                    if (b == r.hdr[1]) begin
                        // ack: send data (case 3/4) or take data
                        next_r.st = (r.cs == t0_pkg::case3 ||
                            r.cs == t0_pkg::case4) ? st_data : st_rdata;
                        if (r.cnt == t0_pkg::cnt_reset) begin
                            next_r.cnt = t0_pkg::full_256;
                        end
                    end else begin
                        next_r.sw1 = b;
                        next_r.st = st_sw2;
                    end
                end
            end
            st_data: begin
                if (req_data_valid && link.cmd_ready) begin
                    next_r.cnt = r.cnt - 9'h001;
                    if (r.cnt == 9'h001) begin
                        next_r.after_data = 1'b1;
                        next_r.st = st_proc;
                    end
                end
            end
            st_rdata: begin
                if (rx) begin
                    next_r.rd = b;
                    next_r.rd_valid = 1'b1;
                    next_r.cnt = r.cnt - 9'h001;
                    if (r.cnt == 9'h001) begin
                        next_r.st = st_proc;
                    end
                end
            end
            st_sw2: begin
                if (rx) begin
                    next_r.idx = t0_pkg::idx_reset;
                    next_r.st = st_hdr;
                    next_r.after_data = 1'b0;
                    if (r.sw1 == t0_pkg::sw1_relen) begin
                        next_r.hdr[4] = b; // resend, new p3
                    end else if (r.sw1 == t0_pkg::sw1_more) begin
                        // fetch with get response, p3 = xx
                        next_r.hdr[1] = t0_pkg::ins_get_response;
                        next_r.hdr[2] = t0_pkg::p3_zero;
                        next_r.hdr[3] = t0_pkg::p3_zero;
                        next_r.hdr[4] = b;
                        next_r.cs = t0_pkg::case2;
                    end else if (r.cs == t0_pkg::case4 && r.after_data &&
                        t0_pkg::is_continue_status(r.sw1, b)) begin
                        next_r.hdr[1] = t0_pkg::ins_get_response;
                        next_r.hdr[2] = t0_pkg::p3_zero;
                        next_r.hdr[3] = t0_pkg::p3_zero;
                        next_r.hdr[4] = t0_pkg::p3_zero;
                        next_r.cs = t0_pkg::case2;
                    end else begin
                        // any other status ends the command
                        next_r.out_sw1 = r.sw1;
                        next_r.out_sw2 = b;
                        next_r.done = 1'b1;
                        next_r.st = st_idle;
                    end
                end
            end
            default: begin
                next_r.st = st_idle;
            end
        endcase
    end

    always_ff @(posedge link.clk) begin
        if (!link.nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule : t0_terminal
`default_nettype wire

// *** testbench/t0_link_asserts.sv ***
// concurrent checks on the t0 byte link between terminal and card
`timescale 1ns/1ns
`default_nettype none
module t0_link_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_valid,
    input wire logic rsp_ready
);
    // ------------------------------------------------------------
    // helper: last two card bytes and byte index of each burst
    // ------------------------------------------------------------
    logic cf;
    logic rf;
    logic [7:0] r1;
    logic [7:0] r0;
    logic [7:0] pk;
    logic [7:0] pl;
    logic [7:0] ins_now;
    logic [2:0] idx;
    assign cf = cmd_valid && cmd_ready;
    assign rf = rsp_valid && rsp_ready;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r1 <= 8'h00;
            r0 <= 8'h00;
            pk <= 8'h00;
            pl <= 8'h00;
            ins_now <= 8'h00;
            idx <= 3'h0;
        end else begin
            if (rf) begin
                r1 <= r0;
                r0 <= rsp_data;
                idx <= 3'h0;
            end else if (cf && idx != 3'h7) begin
                idx <= idx + 3'h1;
            end
            // a burst opened right after a pair remembers that pair
            if (cf && idx == 3'h0) begin
                pk <= r1;
                pl <= r0;
            end
            if (cf && idx == 3'h1) begin
                ins_now <= cmd_data;
            end
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    cmd_hold_a: assert property (
        cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
        else $error("command byte withdrawn before taken");
    rsp_hold_a: assert property (
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("card byte withdrawn before taken");
    answer_bound_a: assert property (
        cf |-> ##[1:200] (cmd_valid || rsp_valid))
        else $error("link went silent after a command byte");
    one_talker_a: assert property (
        !(cmd_valid && rsp_valid))
        else $error("both ends talk at once");
    relen_p3_a: assert property (
        cf && idx == 3'h4 && pk == t0_pkg::sw1_relen |-> cmd_data == pl)
        else $error("resent header carries wrong length");
    relen_ins_a: assert property (
        cf && idx == 3'h1 && pk == t0_pkg::sw1_relen
        |-> cmd_data == ins_now)
        else $error("resent header changed its instruction");
    getresp_ins_a: assert property (
        cf && idx == 3'h1 && pk == t0_pkg::sw1_more
        |-> cmd_data == t0_pkg::ins_get_response)
        else $error("fetch after more-data is not get response");
    getresp_p3_a: assert property (
        cf && idx == 3'h4 && pk == t0_pkg::sw1_more |-> cmd_data <= pl)
        else $error("get response asks more than offered");

    relen_c: cover property (cf && idx == 3'h4 && pk == t0_pkg::sw1_relen);
    more_c: cover property (cf && idx == 3'h4 && pk == t0_pkg::sw1_more);
    err_c: cover property (rf && rsp_data == t0_pkg::sw1_err);
endmodule : t0_link_asserts
`default_nettype wire

// *** testbench/tb_t0_apdu_transport_layer.sv ***
// self-checking bench for the t0 apdu transport link
`timescale 1ns/1ns
`default_nettype none
`define chk(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH at %0t: value differs, line %0d", $time, \
    `__LINE__); end end
module tb_t0_apdu_transport_layer;
    // ------------------------------------------------------------
    // signals and rows
    // ------------------------------------------------------------
    typedef struct packed {
        t0_pkg::apdu_case_t cs;
        logic [7:0] ins;
        logic [7:0] p3;
        logic [7:0] le;
        logic [8:0] avail;
        logic ferr;
        logic [8:0] nrsp;
        logic [8:0] ndat;
        logic [7:0] sw1;
        logic [7:0] lins;
    } row_t;
    localparam logic [7:0] ok = t0_pkg::sw1_ok;
    localparam logic [7:0] er = t0_pkg::sw1_err;
    localparam t0_pkg::apdu_case_t c1 = t0_pkg::case1;
    localparam t0_pkg::apdu_case_t c2 = t0_pkg::case2;
    localparam t0_pkg::apdu_case_t c3 = t0_pkg::case3;
    localparam t0_pkg::apdu_case_t c4 = t0_pkg::case4;
    // ndat of 1ff means the data count is not judged
    row_t rows [12] = '{
        '{c1, 8'h10, 8'h00, 8'h00, 9'h020, 1'b0, 9'h0, 9'h0, ok, 8'h10},
        '{c1, 8'h10, 8'h00, 8'h00, 9'h020, 1'b1, 9'h0, 9'h0, er, 8'h10},
        '{c2, 8'hca, 8'h00, 8'h08, 9'h008, 1'b0, 9'h8, 9'h0, ok, 8'hca},
        '{c2, 8'hca, 8'h00, 8'h20, 9'h010, 1'b0, 9'h10, 9'h0, ok, 8'hca},
        '{c2, 8'hca, 8'h00, 8'h00, 9'h030, 1'b0, 9'h30, 9'h0, ok, 8'hca},
        '{c2, 8'hca, 8'h00, 8'h04, 9'h00c, 1'b0, 9'hc, 9'h0, ok, 8'hc0},
        '{c2, 8'hca, 8'h00, 8'h00, 9'h100, 1'b0, 9'h100, 9'h0, ok, 8'hc0},
        '{c2, 8'hca, 8'h00, 8'h08, 9'h008, 1'b1, 9'h0, 9'h0, er, 8'hca},
        '{c3, 8'hd6, 8'h03, 8'h00, 9'h000, 1'b0, 9'h0, 9'h3, ok, 8'hd6},
        '{c3, 8'hd6, 8'hff, 8'h00, 9'h000, 1'b0, 9'h0, 9'hff, ok, 8'hd6},
        '{c4, 8'he2, 8'h02, 8'h00, 9'h006, 1'b0, 9'h6, 9'h2, ok, 8'hc0},
        '{c4, 8'he2, 8'h02, 8'h00, 9'h006, 1'b1, 9'h0, 9'h1ff, er, 8'he2}
    };
    row_t hrow;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0][7:0] req_hdr = '0;
    t0_pkg::apdu_case_t req_case = t0_pkg::case1;
    logic [7:0] req_le = 8'h00;
    logic req_valid = 1'b0;
    logic [7:0] req_data = 8'h00;
    logic req_data_valid = 1'b1;
    logic [8:0] avail_len = 9'h020;
    logic [7:0] chunk_max = 8'hff;
    logic force_error = 1'b0;
    logic req_ready;
    logic req_data_ready;
    logic resp_data_valid;
    logic [7:0] resp_sw1;
    logic [7:0] resp_sw2;
    logic resp_done;
    logic [7:0] last_ins;
    logic [7:0] resp_data;
    logic cmd_done;
    logic saw_done = 1'b0;
    logic [7:0] last_d = 8'h00;
    logic dfire = 1'b0;
    logic done = 1'b0;
    logic [8:0] n_rsp = '0;
    logic [8:0] n_dat = '0;
    int errors = 0;
    int n_compared = 0;

    always #50 clk = ~clk;

    t0_link_if i_t0_link_if (.clk(clk), .nrst(nrst));
    t0_card i_t0_card (.link(i_t0_link_if), .avail_len(avail_len),
        .chunk_max(chunk_max), .force_error(force_error),
        .last_ins(last_ins), .cmd_done(cmd_done));
    t0_terminal i_t0_terminal (.link(i_t0_link_if), .req_hdr(req_hdr),
        .req_case(req_case), .req_le(req_le), .req_valid(req_valid),
        .req_ready(req_ready), .req_data(req_data),
        .req_data_valid(req_data_valid), .req_data_ready(req_data_ready),
        .resp_data(resp_data), .resp_data_valid(resp_data_valid),
        .resp_sw1(resp_sw1), .resp_sw2(resp_sw2), .resp_done(resp_done));
    t0_link_asserts i_t0_link_asserts (.clk(clk), .nrst(nrst),
        .cmd_data(i_t0_link_if.cmd_data), .cmd_valid(i_t0_link_if.cmd_valid),
        .cmd_ready(i_t0_link_if.cmd_ready), .rsp_data(i_t0_link_if.rsp_data),
        .rsp_valid(i_t0_link_if.rsp_valid),
        .rsp_ready(i_t0_link_if.rsp_ready));

    // ------------------------------------------------------------
    // monitors: count handshakes where all values have settled
    // ------------------------------------------------------------
    always @(negedge clk) begin
        if (resp_data_valid === 1'b1) n_rsp++;
        if (resp_done === 1'b1) done = 1'b1;
        if (cmd_done === 1'b1) saw_done = 1'b1;
        if (resp_data_valid === 1'b1) last_d = resp_data;
        dfire = (req_data_valid && req_data_ready) === 1'b1;
        if (dfire) n_dat++;
    end
    always @(posedge clk) begin
        if (dfire) req_data <= req_data + 8'h01;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic start(input row_t r);
        int i;
        @(posedge clk);
        #1;
        avail_len = r.avail;
        force_error = r.ferr;
        req_hdr = {r.p3, 8'h00, 8'h00, r.ins, 8'h00};
        req_case = r.cs;
        req_le = r.le;
        req_valid = 1'b1;
        n_rsp = '0;
        n_dat = '0;
        done = 1'b0;
        saw_done = 1'b0;
        for (i = 0; i < 50 && req_ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 50) begin
            errors++;
            conclude();
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
    endtask : start

    task automatic finish(input row_t r);
        int i;
        for (i = 0; i < 8000 && !done; i++) @(posedge clk);
        if (!done) begin
            errors++;
            conclude();
        end
        `chk(n_rsp, r.nrsp)
        `chk(resp_sw1, r.sw1)
        `chk(resp_sw2, t0_pkg::sw2_ok)
        `chk(last_ins, r.lins)
        if (r.ndat != 9'h1ff) `chk(n_dat, r.ndat)
        `chk(saw_done, 1'b1)
        if (r.nrsp != 9'h0) `chk(last_d, 8'h01)
    endtask : finish

    task automatic conclude;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        foreach (rows[k]) begin
            start(rows[k]);
            finish(rows[k]);
        end
        // four-byte card buffer: answers come back in 61 pieces
        hrow = rows[2];
        hrow.lins = t0_pkg::ins_get_response;
        #1;
        chunk_max = 8'h04;
        start(hrow);
        finish(hrow);
        // reset in the middle of a long data phase
        start(rows[9]);
        repeat (30) @(posedge clk);
        #1;
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        @(negedge clk);
        `chk(i_t0_link_if.rsp_valid, 1'b0)
        `chk(i_t0_link_if.cmd_valid, 1'b0)
        `chk(req_ready, 1'b1)
        start(rows[10]);
        finish(rows[10]);
        conclude();
    end
endmodule : tb_t0_apdu_transport_layer
`default_nettype wire
